//--- design/lax_pkg.sv
// Shared constants for the extended-address instruction executor
package lax_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CMD   = 8'h00;
  localparam logic [7:0] OFS_ACC   = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_TPTR  = 8'h0C;
  localparam logic [7:0] OFS_TBHI  = 8'h10;
  localparam logic [7:0] OFS_DADR  = 8'h14;
  localparam logic [7:0] OFS_DDAT  = 8'h18;
  localparam logic [7:0] OFS_PADR  = 8'h1C;
  localparam logic [7:0] OFS_PDAT  = 8'h20;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CMD_BIT_LSB  = 8;
  localparam int CMD_ADR_LSB  = 16;
  localparam int ST_SKIP_BIT  = 8;
  localparam int ST_CYC_LSB   = 12;
  localparam int TP_UP_LSB    = 8;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [7:0] ALL_ONES  = 8'hFF;
  localparam logic [7:0] ONE       = 8'h01;
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  // ----------------------------------------
  // Operation codes in the command word
  // ----------------------------------------
  localparam logic [4:0] OP_NOP                = 5'h00;
  localparam logic [4:0] DEC_SKIP_ZERO_OP      = 5'h01;
  localparam logic [4:0] DEC_SKIP_ZERO_ACC_OP  = 5'h02;
  localparam logic [4:0] BYTE_SET_OP           = 5'h03;
  localparam logic [4:0] BIT_SET_OP            = 5'h04;
  localparam logic [4:0] INC_SKIP_ZERO_OP      = 5'h05;
  localparam logic [4:0] INC_SKIP_ZERO_ACC_OP  = 5'h06;
  localparam logic [4:0] NONZERO_BIT_SKIP_OP   = 5'h07;
  localparam logic [4:0] NONZERO_BYTE_SKIP_OP  = 5'h08;
  localparam logic [4:0] ZERO_BYTE_SKIP_OP     = 5'h09;
  localparam logic [4:0] ZERO_MOVE_SKIP_OP     = 5'h0A;
  localparam logic [4:0] ZERO_BIT_SKIP_OP      = 5'h0B;
  localparam logic [4:0] SUBTRACT_OP           = 5'h0C;
  localparam logic [4:0] SUBTRACT_TO_MEM_OP    = 5'h0D;
  localparam logic [4:0] NIBBLE_EXCHANGE_OP    = 5'h0E;
  localparam logic [4:0] NIBBLE_EXCH_ACC_OP    = 5'h0F;
  localparam logic [4:0] PAGE_TABLE_READ_OP    = 5'h10;
  localparam logic [4:0] FINAL_TABLE_READ_OP   = 5'h11;
  localparam logic [4:0] PREINC_TABLE_READ_OP  = 5'h12;
  localparam logic [4:0] PREINC_FINAL_READ_OP  = 5'h13;
  localparam logic [4:0] EXCLUSIVE_OR_OP       = 5'h14;
  localparam logic [4:0] EXCLUSIVE_OR_MEM_OP   = 5'h15;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_TABLE, ST_SKIP_FETCH, ST_SKIP_DUMMY
  } seq_type;
endpackage

//--- design/lax_exec.sv
// Extended-address instruction executor with Avalon-MM register access
`timescale 1ns/1ps
`default_nettype none
module lax_exec #(
  parameter int DM_AW = 9,
  parameter int PM_AW = 10
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Status
  output logic             skip_pending
);
  import lax_pkg::*;

  localparam int DM_DEPTH = 1 << DM_AW;
  localparam int PM_DEPTH = 1 << PM_AW;

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  logic [7:0]       dmem [0:DM_DEPTH-1];
  logic [15:0]      pmem [0:PM_DEPTH-1];
  seq_type          state_r;
  logic [4:0]       op_r;
  logic [2:0]       bit_r;
  logic [DM_AW-1:0] m_r;
  logic [7:0]       acc_r;
  logic             carry_flag_r;
  logic             zero_flag_r;
  logic             nibble_borrow_flag_r;
  logic             arith_range_exceeded_flag_r;
  logic             signed_borrow_flag_r;
  logic             chained_nil_flag_r;
  logic [7:0]       table_pointer_lower_r;
  logic [7:0]       table_pointer_upper_r;
  logic [7:0]       table_high_result_reg_r;
  logic [DM_AW-1:0] dm_adr_r;
  logic [PM_AW-1:0] pm_adr_r;
  logic             skip_pending_r;
  logic [1:0]       last_cyc_r;
  logic             waitrequest_r;
  logic [31:0]      readdata_r;

  assign readdata     = readdata_r;
  assign waitrequest  = waitrequest_r;
  assign skip_pending = skip_pending_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [31:0] rd_val;
  logic [31:0] be_mask;
  logic [31:0] wr_val;
  logic        wr_fire;
  logic        cmd_fire;
  logic [5:0]  flag_vec;

  assign flag_vec = {chained_nil_flag_r, signed_borrow_flag_r, arith_range_exceeded_flag_r,
                     nibble_borrow_flag_r, zero_flag_r, carry_flag_r};
  assign be_mask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};
  // Unselected byte lanes keep what the register already holds
  assign wr_val   = (rd_val & ~be_mask) | (writedata & be_mask);
  // A write lands only at the edge where waitrequest is seen low
  assign wr_fire  = write && !waitrequest_r;
  assign cmd_fire = wr_fire && (address == OFS_CMD);

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_val = '0;
    case (address)
      OFS_CMD:  rd_val = {{(16-DM_AW){1'b0}}, m_r, 5'h00, bit_r, 3'h0, op_r};
      OFS_ACC:  rd_val = {24'h000000, acc_r};
      OFS_STAT: rd_val = {18'h00000, last_cyc_r, 3'h0, skip_pending_r, 2'h0, flag_vec};
      OFS_TPTR: rd_val = {16'h0000, table_pointer_upper_r, table_pointer_lower_r};
      OFS_TBHI: rd_val = {24'h000000, table_high_result_reg_r};
      OFS_DADR: rd_val = {{(32-DM_AW){1'b0}}, dm_adr_r};
      OFS_DDAT: rd_val = {24'h000000, dmem[dm_adr_r]};
      OFS_PADR: rd_val = {{(32-PM_AW){1'b0}}, pm_adr_r};
      OFS_PDAT: rd_val = {16'h0000, pmem[pm_adr_r]};
      default:  rd_val = '0;
    endcase
  end

  // Handshake: one wait cycle, and only while the sequencer is idle so
  // that read data and register contents cannot move under the master
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_r <= 1'b1;
      readdata_r    <= '0;
    end else if ((read || write) && waitrequest_r && state_r == ST_IDLE) begin
      waitrequest_r <= 1'b0;
      readdata_r    <= rd_val;
    end else begin
      waitrequest_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Execute datapath
  // ----------------------------------------
  logic [7:0]       mval;
  logic [7:0]       dec_v;
  logic [7:0]       inc_v;
  logic [7:0]       swp_v;
  logic [7:0]       xor_v;
  logic [8:0]       sub_v;
  logic             bitv;
  logic             dm_we;
  logic [7:0]       dm_wd;
  logic             acc_we;
  logic [7:0]       acc_wd;
  logic             skip;
  logic             sub_fl;
  logic             xor_fl;
  logic             tbl_op;
  logic             tbl_inc;
  logic             tbl_final;
  logic [15:0]      pt_full;
  logic [PM_AW-1:0] tbl_adr;
  logic [15:0]      tbl_word;

  assign mval  = dmem[m_r];
  assign dec_v = mval - ONE;
  assign inc_v = mval + ONE;
  assign swp_v = {mval[3:0], mval[7:4]};
  assign xor_v = acc_r ^ mval;
  assign sub_v = {1'b0, acc_r} - {1'b0, mval};
  assign bitv  = mval[bit_r];
  assign tbl_final = (op_r == FINAL_TABLE_READ_OP) || (op_r == PREINC_FINAL_READ_OP);
  assign pt_full   = {table_pointer_upper_r, table_pointer_lower_r};
  // Final page: upper address bits all ones, lower pointer selects the word
  assign tbl_adr   = tbl_final ? {{(PM_AW-8){1'b1}}, table_pointer_lower_r}
                               : pt_full[PM_AW-1:0];
  assign tbl_word  = pmem[tbl_adr];

  // Decode of the latched operation during its execute cycle
  always_comb begin
    dm_we   = 1'b0;
    dm_wd   = mval;
    acc_we  = 1'b0;
    acc_wd  = acc_r;
    skip    = 1'b0;
    sub_fl  = 1'b0;
    xor_fl  = 1'b0;
    tbl_op  = 1'b0;
    tbl_inc = 1'b0;
    case (op_r)
      DEC_SKIP_ZERO_OP: begin
        dm_we = 1'b1;
        dm_wd = dec_v;
        skip  = (dec_v == BYTE_RST);
      end
      DEC_SKIP_ZERO_ACC_OP: begin
        acc_we = 1'b1;
        acc_wd = dec_v;
        skip   = (dec_v == BYTE_RST);
      end
      BYTE_SET_OP: begin
        dm_we = 1'b1;
        dm_wd = ALL_ONES;
      end
      BIT_SET_OP: begin
        dm_we        = 1'b1;
        dm_wd[bit_r] = 1'b1;
      end
      INC_SKIP_ZERO_OP: begin
        dm_we = 1'b1;
        dm_wd = inc_v;
        skip  = (inc_v == BYTE_RST);
      end
      INC_SKIP_ZERO_ACC_OP: begin
        acc_we = 1'b1;
        acc_wd = inc_v;
        skip   = (inc_v == BYTE_RST);
      end
      NONZERO_BIT_SKIP_OP: skip = bitv;
      NONZERO_BYTE_SKIP_OP: begin
        dm_we = 1'b1;
        skip  = (mval != BYTE_RST);
      end
      ZERO_BYTE_SKIP_OP: begin
        dm_we = 1'b1;
        skip  = (mval == BYTE_RST);
      end
      ZERO_MOVE_SKIP_OP: begin
        acc_we = 1'b1;
        acc_wd = mval;
        skip   = (mval == BYTE_RST);
      end
      ZERO_BIT_SKIP_OP: skip = !bitv;
      SUBTRACT_OP: begin
        acc_we = 1'b1;
        acc_wd = sub_v[7:0];
        sub_fl = 1'b1;
      end
      SUBTRACT_TO_MEM_OP: begin
        dm_we  = 1'b1;
        dm_wd  = sub_v[7:0];
        sub_fl = 1'b1;
      end
      NIBBLE_EXCHANGE_OP: begin
        dm_we = 1'b1;
        dm_wd = swp_v;
      end
      NIBBLE_EXCH_ACC_OP: begin
        acc_we = 1'b1;
        acc_wd = swp_v;
      end
      PAGE_TABLE_READ_OP, FINAL_TABLE_READ_OP: tbl_op = 1'b1;
      PREINC_TABLE_READ_OP, PREINC_FINAL_READ_OP: begin
        tbl_op  = 1'b1;
        tbl_inc = 1'b1;
      end
      EXCLUSIVE_OR_OP: begin
        acc_we = 1'b1;
        acc_wd = xor_v;
        xor_fl = 1'b1;
      end
      EXCLUSIVE_OR_MEM_OP: begin
        dm_we  = 1'b1;
        dm_wd  = xor_v;
        xor_fl = 1'b1;
      end
      default: ;
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Command capture; a command arriving behind a taken skip is the
  // fetched follower and is dropped; its only effect is to clear skip_pending
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      op_r    <= OP_NOP;
      bit_r   <= '0;
      m_r     <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_fire && !skip_pending_r) begin
            op_r    <= wr_val[4:0];
            bit_r   <= wr_val[CMD_BIT_LSB +: 3];
            m_r     <= wr_val[CMD_ADR_LSB +: DM_AW];
            state_r <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (skip)
            state_r <= ST_SKIP_FETCH;
          else if (tbl_op)
            state_r <= ST_TABLE;
          else
            state_r <= ST_IDLE;
        end
        ST_SKIP_FETCH: state_r <= ST_SKIP_DUMMY;
        ST_TABLE, ST_SKIP_DUMMY: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Skip bookkeeping and cycle count of the last instruction
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_pending_r <= 1'b0;
      last_cyc_r     <= '0;
    end else if (state_r == ST_EXEC) begin
      skip_pending_r <= skip;
      last_cyc_r     <= skip ? CYC_THREE : (tbl_op ? CYC_TWO : CYC_ONE);
    end else if (cmd_fire && skip_pending_r) begin
      skip_pending_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Architectural registers
  // ----------------------------------------
  // Accumulator
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      acc_r <= BYTE_RST;
    else if (state_r == ST_EXEC && acc_we)
      acc_r <= acc_wd;
    else if (wr_fire && address == OFS_ACC)
      acc_r <= wr_val[7:0];
  end

  // Status flags; skip, swap, set and table operations leave them alone
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_flag_r                <= 1'b0;
      zero_flag_r                 <= 1'b0;
      nibble_borrow_flag_r        <= 1'b0;
      arith_range_exceeded_flag_r <= 1'b0;
      signed_borrow_flag_r        <= 1'b0;
      chained_nil_flag_r          <= 1'b0;
    end else if (state_r == ST_EXEC && sub_fl) begin
      // Carry and nibble flags read as "no borrow"
      carry_flag_r                <= !sub_v[8];
      zero_flag_r                 <= (sub_v[7:0] == BYTE_RST);
      nibble_borrow_flag_r        <= (acc_r[3:0] >= mval[3:0]);
      arith_range_exceeded_flag_r <= (acc_r[7] ^ mval[7]) & (acc_r[7] ^ sub_v[7]);
      signed_borrow_flag_r        <= !(sub_v[7] ^ ((acc_r[7] ^ mval[7]) & (acc_r[7] ^ sub_v[7])));
      chained_nil_flag_r          <= (sub_v[7:0] == BYTE_RST);
    end else if (state_r == ST_EXEC && xor_fl) begin
      zero_flag_r                 <= (xor_v == BYTE_RST);
    end else if (wr_fire && address == OFS_STAT) begin
      {chained_nil_flag_r, signed_borrow_flag_r, arith_range_exceeded_flag_r,
       nibble_borrow_flag_r, zero_flag_r, carry_flag_r} <= wr_val[5:0];
    end
  end

  // Table pointer; pre-increment happens in the execute cycle so the
  // following table cycle already sees the new value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      table_pointer_lower_r <= BYTE_RST;
      table_pointer_upper_r <= BYTE_RST;
    end else if (state_r == ST_EXEC && tbl_inc) begin
      table_pointer_lower_r <= table_pointer_lower_r + ONE;
    end else if (wr_fire && address == OFS_TPTR) begin
      table_pointer_lower_r <= wr_val[7:0];
      table_pointer_upper_r <= wr_val[TP_UP_LSB +: 8];
    end
  end

  // Table high result
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      table_high_result_reg_r <= BYTE_RST;
    else if (state_r == ST_TABLE)
      table_high_result_reg_r <= tbl_word[15:8];
  end

  // Memory window pointers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dm_adr_r <= '0;
      pm_adr_r <= '0;
    end else if (wr_fire && address == OFS_DADR) begin
      dm_adr_r <= wr_val[DM_AW-1:0];
    end else if (wr_fire && address == OFS_PADR) begin
      pm_adr_r <= wr_val[PM_AW-1:0];
    end
  end

  // ----------------------------------------
  // Memories
  // ----------------------------------------
  // Data memory: execution and bus never write in the same cycle since
  // the bus is only answered while the sequencer is idle
  always_ff @(posedge core_clk) begin
    if (state_r == ST_EXEC && dm_we)
      dmem[m_r] <= dm_wd;
    else if (state_r == ST_TABLE)
      dmem[m_r] <= tbl_word[7:0];
    else if (wr_fire && address == OFS_DDAT)
      dmem[dm_adr_r] <= wr_val[7:0];
  end

  // Program memory is loaded over the bus only
  always_ff @(posedge core_clk) begin
    if (wr_fire && address == OFS_PDAT)
      pmem[pm_adr_r] <= wr_val[15:0];
  end

endmodule
`default_nettype wire

//--- dv/lax_exec_assertions.sv
// Port-level checks of bus handshake and skip bookkeeping for the executor
`timescale 1ns/1ps
`default_nettype none
module lax_exec_checker
  import lax_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Avalon-MM slave
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Status
  input wire logic        skip_pending
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic       cmd_acc;
  logic       noskip_op;
  logic [2:0] since_cmd_r;
  // Ops that can never skip; unknown codes behave as no-ops
  assign cmd_acc = write && !waitrequest && (address == OFS_CMD);
  assign noskip_op = (writedata[4:0] == OP_NOP) || (writedata[4:0] == BYTE_SET_OP) ||
                     (writedata[4:0] == BIT_SET_OP) || (writedata[4:0] >= SUBTRACT_OP);
  // Cycles since the last accepted command; saturates so it never wraps back
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_cmd_r <= 3'h7;
    end else if (cmd_acc) begin
      since_cmd_r <= 3'h0;
    end else if (since_cmd_r != 3'h7) begin
      since_cmd_r <= since_cmd_r + 3'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_cmd_acc;
    write && !waitrequest && (address == OFS_CMD);
  endsequence
  sequence s_quiet_skip;
    !skip_pending [*4];
  endsequence
  property p_wait_one;
    !waitrequest |=> waitrequest;
  endproperty
  property p_answer_req;
    !waitrequest |-> (read ^ write);
  endproperty
  property p_bounded;
    $rose(read || write) |-> ##[1:8] !waitrequest;
  endproperty
  property p_rdata_hold;
    !$stable(readdata) |-> !waitrequest;
  endproperty
  property p_skip_src;
    $rose(skip_pending) |-> (since_cmd_r <= 3'h3);
  endproperty
  property p_skip_clear;
    s_cmd_acc ##0 skip_pending |=> ##[0:1] !skip_pending;
  endproperty
  property p_fell_skip;
    $fell(skip_pending) |-> (since_cmd_r <= 3'h2);
  endproperty
  property p_noskip;
    s_cmd_acc ##0 (noskip_op && !skip_pending) |=> s_quiet_skip;
  endproperty
  a_wait_one:
    assert property (p_wait_one) else $error("waitrequest low longer than one cycle");
  a_answer_req:
    assert property (p_answer_req) else $error("answer without a single request");
  a_bounded:
    assert property (p_bounded) else $error("request not answered in time");
  a_rdata_hold:
    assert property (p_rdata_hold) else $error("readdata changed outside an answer");
  a_skip_src:
    assert property (p_skip_src) else $error("skip raised without a recent command");
  a_skip_clear:
    assert property (p_skip_clear) else $error("discarded command left skip pending");
  a_fell_skip:
    assert property (p_fell_skip) else $error("skip cleared without a command");
  a_noskip:
    assert property (p_noskip) else $error("non-skip command raised skip");
endmodule
bind lax_exec lax_exec_checker i_lax_exec_checker (.core_clk(core_clk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .skip_pending(skip_pending));
`default_nettype wire

//--- dv/testbench.sv
// Random self-checking bench for the extended-address executor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lax_pkg::*;
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        skip_pending;
  int          err_total;
  int          n_checks;
  logic [4:0]  op;
  logic [2:0]  b;
  logic [7:0]  a, m, ea, em, et;
  logic [5:0]  f, ef;
  logic [15:0] tp, tpx, pw;
  logic [9:0]  pidx;
  logic [8:0]  dadr;
  logic [1:0]  cyc;
  logic        sk;
  logic [31:0] q;
  lax_exec i_lax_exec (.core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .skip_pending(skip_pending));
  // ----------------------------------------
  // Clock, checks and bus tasks
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // One access; an idle edge first so no strobe is driven twice in one step
  task automatic bus(input logic rd, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    address   <= ad;
    writedata <= d;
    read      <= rd;
    write     <= !rd;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (k >= 50) begin
      $display("ERROR waitrequest expected 0 seen 1");
      err_total++;
      test_done();
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] e);
    bus(1'b1, ad, 32'h0);
    chk(nm, e, q);
  endtask
  // ----------------------------------------
  // Expected outcome of one instruction
  // ----------------------------------------
  function automatic void model();
    logic [7:0] r;
    logic       ovf;
    r = a - m;
    ovf = (a[7] != m[7]) && (r[7] != a[7]);
    ea = a;
    em = m;
    ef = f;
    sk = 1'b0;
    tpx = tp;
    if (op == PREINC_TABLE_READ_OP || op == PREINC_FINAL_READ_OP) tpx[7:0] = tp[7:0] + 8'h01;
    case (op)
      DEC_SKIP_ZERO_OP:     em = m - ONE;
      DEC_SKIP_ZERO_ACC_OP: ea = m - ONE;
      BYTE_SET_OP:          em = ALL_ONES;
      BIT_SET_OP:           em[b] = 1'b1;
      INC_SKIP_ZERO_OP:     em = m + ONE;
      INC_SKIP_ZERO_ACC_OP: ea = m + ONE;
      ZERO_MOVE_SKIP_OP:    ea = m;
      SUBTRACT_OP:          ea = r;
      SUBTRACT_TO_MEM_OP:   em = r;
      NIBBLE_EXCHANGE_OP:   em = {m[3:0], m[7:4]};
      NIBBLE_EXCH_ACC_OP:   ea = {m[3:0], m[7:4]};
      EXCLUSIVE_OR_OP:      ea = a ^ m;
      EXCLUSIVE_OR_MEM_OP:  em = a ^ m;
      default:              ;
    endcase
    // Skip decision from the result or the original byte
    case (op)
      DEC_SKIP_ZERO_OP, INC_SKIP_ZERO_OP:         sk = (em == 8'h00);
      DEC_SKIP_ZERO_ACC_OP, INC_SKIP_ZERO_ACC_OP: sk = (ea == 8'h00);
      NONZERO_BIT_SKIP_OP:                        sk = m[b];
      NONZERO_BYTE_SKIP_OP:                       sk = (m != 8'h00);
      ZERO_BYTE_SKIP_OP, ZERO_MOVE_SKIP_OP:       sk = (m == 8'h00);
      ZERO_BIT_SKIP_OP:                           sk = !m[b];
      default:                                    ;
    endcase
    if (op == SUBTRACT_OP || op == SUBTRACT_TO_MEM_OP) begin
      ef = {(r == 8'h00), !(r[7] ^ ovf), ovf, (a[3:0] >= m[3:0]), (r == 8'h00), (a >= m)};
    end
    if (op == EXCLUSIVE_OR_OP || op == EXCLUSIVE_OR_MEM_OP) ef[1] = ((a ^ m) == 8'h00);
    pidx = (op == FINAL_TABLE_READ_OP || op == PREINC_FINAL_READ_OP) ?
           {2'h3, tpx[7:0]} : tpx[9:0];
    cyc = sk ? CYC_THREE : CYC_ONE;
    if (op >= PAGE_TABLE_READ_OP && op <= PREINC_FINAL_READ_OP) begin
      em = pw[7:0];
      et = pw[15:8];
      cyc = CYC_TWO;
    end
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    err_total = 0;
    n_checks = 0;
    et = 8'h00;
    void'($urandom(32'h3D30C5F5));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values, read-only and unmapped places
    rdc("acc", OFS_ACC, 32'h0);
    rdc("stat", OFS_STAT, 32'h0);
    rdc("tptr", OFS_TPTR, 32'h0);
    bus(1'b0, OFS_TBHI, 32'hFFFFFFFF);
    rdc("tbl_high", OFS_TBHI, 32'h0);
    bus(1'b0, 8'h40, 32'hFFFFFFFF);
    rdc("unmapped", 8'h40, 32'h0);
    $display("test reset done");
    for (int t = 0; t < 150; t++) begin
      op = (t < 22) ? 5'(t) : 5'($urandom_range(0, 21));
      b = 3'($urandom);
      a = 8'($urandom);
      f = 6'($urandom);
      tp = 16'($urandom);
      pw = 16'($urandom);
      dadr = 9'($urandom);
      case ($urandom_range(0, 3))
        0:       m = 8'h00;
        1:       m = ONE;
        2:       m = ALL_ONES;
        default: m = 8'($urandom);
      endcase
      model();
      bus(1'b0, OFS_ACC, {24'h0, a});
      bus(1'b0, OFS_STAT, {26'h0, f});
      bus(1'b0, OFS_TPTR, {16'h0, tp});
      bus(1'b0, OFS_DADR, {23'h0, dadr});
      bus(1'b0, OFS_DDAT, {24'h0, m});
      bus(1'b0, OFS_PADR, {22'h0, pidx});
      bus(1'b0, OFS_PDAT, {16'h0, pw});
      bus(1'b0, OFS_CMD, {7'h0, dadr, 5'h0, b, 3'h0, op});
      rdc("acc", OFS_ACC, {24'h0, ea});
      rdc("stat", OFS_STAT, {18'h0, cyc, 3'h0, sk, 2'h0, ef});
      rdc("byte", OFS_DDAT, {24'h0, em});
      rdc("tbl_high", OFS_TBHI, {24'h0, et});
      rdc("tptr", OFS_TPTR, {16'h0, tpx});
      chk("skip_pending", {31'h0, sk}, {31'h0, skip_pending});
      if (sk) begin
        bus(1'b0, OFS_CMD, {7'h0, dadr, 8'h0, 3'h0, BYTE_SET_OP});
        rdc("byte", OFS_DDAT, {24'h0, em});
        chk("skip_pending", 32'h0, {31'h0, skip_pending});
      end
      $display("test %0d op %h done", t, op);
    end
    test_done();
  end
endmodule
`default_nettype wire
